/* File: shared/wdt_consts.svh */
// constants for the watchdog timer core
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define WDT_CNT_W        32
`define WDT_LOAD_RST     32'hFFFF_FFFF
`define WDT_CNT_ZERO     32'h0000_0000
`endif

/* File: shared/wdt_pkg.sv */
// types for the watchdog timer core
`include "wdt_consts.svh"
package wdt_pkg;
  typedef enum logic [1:0] {
    WDT_IDLE,
    WDT_FIRST,
    WDT_SECOND
  } wdt_state_t;

  typedef struct packed {
    logic run_clock_gate;
    logic sleep_clock_gate;
    logic deepsleep_clock_gate;
  } wdt_gate_t;

  typedef struct packed {
    logic irq_en;
    logic reset_enable_bit;
    logic nmi_mode;
  } wdt_ctrl_t;
endpackage

/* File: core/wdt_core.sv */
// watchdog timer core with loose control and status ports
//
// Behaviour
// - any write to interrupt clear drops pending interrupt and restarts sequence
// - second time-out with interrupt uncleared resets system only if reset enabled
// - nmi mode sends nmi on time-out and also sets masked status
// - a load write reloads counter and restarts countdown from that value
// - software reset returns watchdog to reset state
// - load register readback returns value last written
// - value register readback returns the present count
// - run, sleep and deep-sleep clock gates enable the module independently
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.svh"
module wdt_core
  import wdt_pkg::*;
(
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_sw_reset_reg,
  input  wire wdt_gate_t             i_gates,
  input  wire logic                  i_in_sleep,
  input  wire logic                  i_in_deepsleep,
  input  wire wdt_ctrl_t             i_control_reg,
  input  wire logic                  i_test_stall,
  input  wire logic                  i_debug_halt,
  input  wire logic                  i_load_we,
  input  wire logic [`WDT_CNT_W-1:0] i_load_data,
  input  wire logic                  i_irq_clear_we,
  output logic [`WDT_CNT_W-1:0]      o_count_reload_reg,
  output logic [`WDT_CNT_W-1:0]      o_current_count_reg,
  output logic                       o_raw_irq_status,
  output logic                       o_masked_irq_status,
  output logic                       o_irq,
  output logic                       o_nmi,
  output logic                       o_sys_reset,
  output logic                       o_running
);

  logic [`WDT_CNT_W-1:0] load_q;
  logic [`WDT_CNT_W-1:0] load_d;
  logic [`WDT_CNT_W-1:0] cnt_q;
  logic [`WDT_CNT_W-1:0] cnt_d;
  logic                  ris_q;
  logic                  ris_d;
  logic                  mis_q;
  logic                  mis_d;
  logic                  nmi_q;
  logic                  nmi_d;
  logic                  irq_q;
  logic                  irq_d;
  logic                  rst_out_q;
  logic                  rst_out_d;
  logic                  run_q;
  logic                  run_d;
  wdt_state_t            state_q;
  wdt_state_t            state_d;

  wire clr_all   = i_rst | i_sw_reset_reg;

  wire in_run    = ~i_in_sleep & ~i_in_deepsleep;
  wire run_gate  = in_run & i_gates.run_clock_gate;
  wire slp_gate  = i_in_sleep & ~i_in_deepsleep & i_gates.sleep_clock_gate;
  wire dslp_gate = i_in_deepsleep & i_gates.deepsleep_clock_gate;
  wire gate_on   = run_gate | slp_gate | dslp_gate;

  wire stalled   = i_test_stall & i_debug_halt;
  wire enabled   = i_control_reg.irq_en;
  wire tick      = gate_on & enabled & ~stalled;
  wire at_zero   = (cnt_q == `WDT_CNT_ZERO);
  wire write_any = i_load_we | i_irq_clear_we;
  wire timeout   = tick & at_zero & ~write_any;
  wire [`WDT_CNT_W-1:0] cnt_dec = cnt_q - `WDT_CNT_W'(1);

  wire pending   = (state_q == WDT_SECOND);
  wire first_to  = timeout & ~pending;
  wire second_to = timeout & pending;

  wire mask_en   = i_control_reg.irq_en | i_control_reg.nmi_mode;
  wire irq_route = i_control_reg.irq_en & ~i_control_reg.nmi_mode;

  assign load_d = i_load_we ? i_load_data : load_q;

  always_comb begin
    cnt_d = cnt_q;
    if (i_load_we) begin
      cnt_d = i_load_data;
    end else if (i_irq_clear_we) begin
      cnt_d = load_q;
    end else if (tick) begin
      cnt_d = at_zero ? load_q : cnt_dec;
    end
  end

  always_comb begin
    state_d   = state_q;
    ris_d     = ris_q;
    rst_out_d = rst_out_q;
    case (state_q)
      WDT_IDLE: begin
        if (i_irq_clear_we) begin
          ris_d   = 1'b0;
          state_d = enabled ? WDT_FIRST : WDT_IDLE;
        end else if (first_to) begin
          ris_d   = 1'b1;
          state_d = WDT_SECOND;
        end else if (enabled) begin
          state_d = WDT_FIRST;
        end
      end
      WDT_FIRST: begin
        if (i_irq_clear_we) begin
          ris_d   = 1'b0;
          state_d = enabled ? WDT_FIRST : WDT_IDLE;
        end else if (first_to) begin
          ris_d   = 1'b1;
          state_d = WDT_SECOND;
        end
      end
      WDT_SECOND: begin
        if (i_irq_clear_we) begin
          ris_d   = 1'b0;
          state_d = enabled ? WDT_FIRST : WDT_IDLE;
        end else if (second_to && i_control_reg.reset_enable_bit) begin
          rst_out_d = 1'b1;
        end
      end
      default: begin
        ris_d   = 1'b0;
        state_d = WDT_IDLE;
      end
    endcase
  end

  assign mis_d = ris_d & mask_en;
  assign nmi_d = ris_d & i_control_reg.nmi_mode;
  assign irq_d = ris_d & irq_route;
  assign run_d = tick;

  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      load_q <= `WDT_LOAD_RST;
    end else begin
      load_q <= load_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      cnt_q <= `WDT_LOAD_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      state_q   <= WDT_IDLE;
      ris_q     <= 1'b0;
      rst_out_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      ris_q     <= ris_d;
      rst_out_q <= rst_out_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      mis_q <= 1'b0;
      nmi_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      mis_q <= mis_d;
      nmi_q <= nmi_d;
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  // outputs straight from flops

  assign o_count_reload_reg  = load_q;
  assign o_current_count_reg = cnt_q;
  assign o_raw_irq_status    = ris_q;
  assign o_masked_irq_status = mis_q;
  assign o_irq               = irq_q;
  assign o_nmi               = nmi_q;
  assign o_sys_reset         = rst_out_q;
  assign o_running           = run_q;

endmodule
`default_nettype wire

/* File: tb/wdt_core_asserts.sv */
// assertions for the watchdog timer core
`timescale 1ns/1ps
`default_nettype none
module wdt_core_asserts import wdt_pkg::*; (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_sw_reset_reg,
  input wire logic        i_load_we,
  input wire logic        i_irq_clear_we,
  input wire wdt_ctrl_t   i_control_reg,
  input wire logic [31:0] i_load_data,
  input wire logic [31:0] o_count_reload_reg,
  input wire logic [31:0] o_current_count_reg,
  input wire logic        o_raw_irq_status,
  input wire logic        o_masked_irq_status,
  input wire logic        o_irq,
  input wire logic        o_nmi,
  input wire logic        o_sys_reset
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst || i_sw_reset_reg);
  a_load_takes: assert property (
    i_load_we |=> o_count_reload_reg == $past(i_load_data) && o_current_count_reg == $past(i_load_data))
    else $error("load write not taken");
  a_clear_drops: assert property (
    i_irq_clear_we && !i_load_we |=> !o_raw_irq_status && o_current_count_reg == o_count_reload_reg)
    else $error("clear did not restart");
  a_nmi_status: assert property (
    o_nmi |-> o_masked_irq_status && o_raw_irq_status && !o_irq) else $error("nmi status wrong");
  a_irq_route: assert property (
    o_irq |-> o_masked_irq_status && o_raw_irq_status && !o_nmi) else $error("irq status wrong");
  a_reset_gate: assert property (
    $rose(o_sys_reset) |-> $past(i_control_reg.reset_enable_bit && o_raw_irq_status))
    else $error("system reset not allowed");
  a_reset_holds: assert property (
    o_sys_reset && !i_rst && !i_sw_reset_reg |=> o_sys_reset) else $error("system reset dropped");
  a_timeout_reload: assert property (
    $rose(o_raw_irq_status) |-> $past(o_current_count_reg) == 0 && o_current_count_reg == o_count_reload_reg)
    else $error("timeout without zero");
  a_count_step: assert property (
    $changed(o_current_count_reg) && !$past(i_load_we || i_irq_clear_we || i_rst || i_sw_reset_reg)
    && $past(o_current_count_reg) != 0 |-> o_current_count_reg == $past(o_current_count_reg) - 1)
    else $error("count step wrong");
endmodule
bind wdt_core wdt_core_asserts u_wdt_core_asserts (.i_sys_clk, .i_rst, .i_sw_reset_reg, .i_load_we,
  .i_irq_clear_we, .i_control_reg, .i_load_data, .o_count_reload_reg, .o_current_count_reg,
  .o_raw_irq_status, .o_masked_irq_status, .o_irq, .o_nmi, .o_sys_reset);
`default_nettype wire

/* File: tb/tb.sv */
// bench for the watchdog timer core
`timescale 1ns/1ps
`default_nettype none
module tb import wdt_pkg::*;;
  logic clk = 0, rst = 1, sw = 0, ld = 0, clr = 0, st = 0, hlt = 0, sl = 0, ds = 0, u = 0;
  wdt_gate_t g = '0;
  wdt_ctrl_t k = '0;
  logic [31:0] d = '0, r, c, s = 32'h0000_92d9;
  logic [4:0] f;
  logic [69:0] q[$];
  int miscompares = 0, checks_done = 0;
  wire logic [31:0] rl, cn;
  wire logic ri, ms, iq, nm, sr, ru;
  wire logic [69:0] ob = {ru, sr, nm, iq, ms, ri, rl, cn};
  wdt_core u_wdt_core (.i_sys_clk(clk), .i_rst(rst), .i_sw_reset_reg(sw), .i_gates(g), .i_in_sleep(sl),
    .i_in_deepsleep(ds), .i_control_reg(k), .i_test_stall(st), .i_debug_halt(hlt), .i_load_we(ld),
    .i_load_data(d), .i_irq_clear_we(clr), .o_count_reload_reg(rl), .o_current_count_reg(cn),
    .o_raw_irq_status(ri), .o_masked_irq_status(ms), .o_irq(iq), .o_nmi(nm), .o_sys_reset(sr), .o_running(ru));
  initial forever #12.5 clk = ~clk;
  function automatic logic [31:0] lf(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // model n edges, note each result
  task automatic cyc(int n = 1);
    repeat (n) begin
      @(posedge clk);
      u = k.irq_en && !(st && hlt) && (ds ? g.deepsleep_clock_gate : sl ? g.sleep_clock_gate : g.run_clock_gate);
      if (rst | sw) begin r = '1; c = '1; f = '0; u = 0; end
      else if (ld) begin r = d; c = d; end
      else if (clr) begin f[0] = 0; c = r; end
      else if (u)
        if (c != 0) c = c - 1;
        else begin f[4] |= f[0] & k.reset_enable_bit; f[0] = 1; c = r; end
      f[3:1] = {f[0] & k.nmi_mode, f[0] & k.irq_en & !k.nmi_mode, f[0] & (k.irq_en | k.nmi_mode)};
      q.push_back({u, f, r, c});
    end
  endtask
  always @(negedge clk) if (q.size() > 0) begin
    checks_done++;
    if (ob !== q[0]) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, ob, q[0]);
    end
    void'(q.pop_front());
  end
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    cyc(12);
    rst <= 0;
    g <= 3'b111;
    for (int m = 0; m < 2; m++) begin
      s = lf(s);
      d <= 32'(s[2:0]) + 2;
      k <= {1'b1, m == 0, m == 1};
      ld <= 1;
      cyc();
      ld <= 0;
      cyc(2 * 32'(s[2:0]) + 8);
      clr <= 1;
      cyc();
      clr <= 0;
      cyc(2);
      sw <= 1;
      cyc();
      sw <= 0;
      cyc();
      $display("timeout test %0d done", m);
    end
    d <= s;
    ld <= 1;
    cyc();
    ld <= 0;
    for (int i = 0; i < 40; i++) begin
      s = lf(s);
      {k, g, sl, ds, st, hlt} <= s[9:0];
      cyc();
    end
    $display("gate test done");
    @(negedge clk);
    #1 close_out();
  end
  initial begin
    #20us;
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
